// >>> calov_defs.svh
// Purpose: named constants of the calibration overlay block
// Assumes: 8-bit register offsets, 16-bit cpu address space
// Notes: included by bare name; definitions only
`ifndef CALOV_DEFS_SVH
`define CALOV_DEFS_SVH

// register offsets from the register block base
`define CALOV_CFG_OFS 8'hfc
`define CALOV_MAP_OFS 8'hf8
`define CALOV_FAH_OFS 8'hf0
`define CALOV_FAL_OFS 8'hf1
`define CALOV_FDH_OFS 8'hf2
`define CALOV_FDL_OFS 8'hf3

// field positions
`define CALOV_SU_BIT 7
`define CALOV_BASE_HI 7
`define CALOV_BASE_LO 3
`define CALOV_EN_BIT 0
`define CALOV_MAP_MASK 8'hf9

// reset values
`define CALOV_MAP_RST 8'h10
`define CALOV_SU_RST 1'h0
`define CALOV_ZERO8 8'h00
`define CALOV_ZERO16 16'h0000

// address decode
`define CALOV_WIN_HI 15
`define CALOV_WIN_LO 11
`define CALOV_IDX_HI 10
`define CALOV_IDX_LO 1
`define CALOV_BLK_BIT 15

// ram shape and secured read values
`define CALOV_BANK_DEPTH 1024
`define CALOV_IDX_W 10
`define CALOV_ONES8 8'hff
`define CALOV_ONES16 16'hffff

`endif

// >>> calov_pkg.sv
// Purpose: types of the calibration overlay block
// Assumes: constants live in calov_defs.svh
// Notes: used only through calov_pkg::name
package calov_pkg;

	typedef enum logic [0:0] {
		CALOV_IDLE = 1'b0,
		CALOV_SPLIT = 1'b1
	} calov_state_type;

	typedef enum logic [1:0] {
		CALOV_SRC_NONE = 2'b00,
		CALOV_SRC_RAM = 2'b01,
		CALOV_SRC_FLASH = 2'b10,
		CALOV_SRC_LOCK = 2'b11
	} calov_src_type;

endpackage : calov_pkg

// >>> calov_ram.sv
// Purpose: 2K byte calibration ram as even and odd byte banks
// Assumes: synchronous read, one access per bank per cycle
// Notes: contents undefined after reset, no reset on the array
`timescale 1ns/1ps
`include "calov_defs.svh"
module calov_ram (
	// clock and enable
	input wire logic clk,
	input wire logic ce,
	// even bank
	input wire logic [`CALOV_IDX_W-1:0] even_idx,
	input wire logic even_we,
	input wire logic [7:0] even_wdata,
	output logic [7:0] even_rdata,
	// odd bank
	input wire logic [`CALOV_IDX_W-1:0] odd_idx,
	input wire logic odd_we,
	input wire logic [7:0] odd_wdata,
	output logic [7:0] odd_rdata
);

	logic [`CALOV_IDX_W-1:0] idx_a [2];
	logic we_a [2];
	logic [7:0] wd_a [2];
	logic [7:0] rd_a [2];

	assign idx_a[0] = even_idx;
	assign idx_a[1] = odd_idx;
	assign we_a[0] = even_we;
	assign we_a[1] = odd_we;
	assign wd_a[0] = even_wdata;
	assign wd_a[1] = odd_wdata;
	assign even_rdata = rd_a[0];
	assign odd_rdata = rd_a[1];

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_bank
			logic [7:0] mem [`CALOV_BANK_DEPTH];
			always_ff @(posedge clk) begin
				if (ce) begin
					if (we_a[g]) begin
						mem[idx_a[g]] <= wd_a[g];
					end
					rd_a[g] <= mem[idx_a[g]];
				end
			end
		end
	endgenerate

endmodule : calov_ram

// >>> calov_top.sv
// Purpose: calibration ram overlay over the 64K flash space
// Assumes: cpu port, register port and flash share clk
// Notes: registers reset asynchronously, unlike the usual sync rst
`timescale 1ns/1ps
`include "calov_defs.svh"
module calov_top (
	// clock, reset and enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// cpu memory port
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic mem_word,
	input wire logic [15:0] mem_wdata,
	output logic mem_wait,
	output logic mem_rvalid,
	output logic [15:0] mem_rdata,
	// flash array side
	output logic flash_rd,
	output logic flash_wr,
	output logic flash_word,
	output logic [15:0] flash_addr,
	output logic [15:0] flash_wdata,
	input wire logic [15:0] flash_rdata,
	input wire logic [1:0] flash_busy,
	// flash super user mode
	output logic flash_su_mode,
	output logic [15:0] flash_address_staging,
	output logic [15:0] flash_data_staging,
	output logic flash_stage_wr,
	// chip security state
	input wire logic chip_secured,
	input wire logic special_single_chip
);

	// register state
	logic su_mode_q;
	logic su_mode_d;
	logic [7:0] map_q;
	logic [7:0] map_d;
	logic [7:0] map_eff_q;
	logic [7:0] fah_q;
	logic [7:0] fah_d;
	logic [7:0] fal_q;
	logic [7:0] fal_d;
	logic [7:0] fdh_q;
	logic [7:0] fdh_d;
	logic [7:0] fdl_q;
	logic [7:0] fdl_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic stage_wr_q;

	// register decode
	logic cfg_sel;
	logic map_sel;
	logic fah_sel;
	logic fal_sel;
	logic fdh_sel;
	logic fdl_sel;
	logic cfg_wr;
	logic map_wr;
	logic fah_wr;
	logic fal_wr;
	logic fdh_wr;
	logic fdl_wr;
	logic [7:0] cfg_val;
	logic [7:0] rd_mux;

	// window decode
	logic [4:0] base_eff;
	logic en_eff;
	logic hit_now;

	// access sequencing
	calov_pkg::calov_state_type state_q;
	calov_pkg::calov_state_type state_d;
	logic idle;
	logic req;
	logic mis;
	logic split;
	logic [15:0] h_addr_q;
	logic [15:0] h_wdata_q;
	logic h_rd_q;
	logic h_wr_q;
	logic acc_go;
	logic acc_hit;
	logic acc_rd;
	logic acc_wr;
	logic acc_word;
	logic [15:0] acc_addr;
	logic [15:0] acc_wdata;

	// ram control
	logic a_odd;
	logic [`CALOV_IDX_W-1:0] idx;
	logic [`CALOV_IDX_W-1:0] even_idx;
	logic ram_go;
	logic even_we;
	logic odd_we;
	logic [7:0] even_wd;
	logic [7:0] odd_wd;
	logic [7:0] even_q;
	logic [7:0] odd_q;

	// read return
	logic lock;
	logic blk_busy;
	logic rvalid_d;
	logic rvalid_q;
	calov_pkg::calov_src_type src_d;
	calov_pkg::calov_src_type src_q;
	logic rd_odd_q;
	logic rd_word_q;
	logic [15:0] ram_word;
	logic [15:0] ram_byte;
	logic [15:0] lock_val;
	logic [15:0] out_val;

	// register decode; reserved offsets fall through to zero
	assign cfg_sel = reg_addr == `CALOV_CFG_OFS;
	assign map_sel = reg_addr == `CALOV_MAP_OFS;
	assign fah_sel = (reg_addr == `CALOV_FAH_OFS) & su_mode_q;
	assign fal_sel = (reg_addr == `CALOV_FAL_OFS) & su_mode_q;
	assign fdh_sel = (reg_addr == `CALOV_FDH_OFS) & su_mode_q;
	assign fdl_sel = (reg_addr == `CALOV_FDL_OFS) & su_mode_q;

	assign cfg_wr = reg_wr & cfg_sel;
	assign map_wr = reg_wr & map_sel;
	assign fah_wr = reg_wr & fah_sel;
	assign fal_wr = reg_wr & fal_sel;
	assign fdh_wr = reg_wr & fdh_sel;
	assign fdl_wr = reg_wr & fdl_sel;

	assign su_mode_d = cfg_wr ? reg_wdata[`CALOV_SU_BIT] : su_mode_q;
	assign map_d = map_wr ? (reg_wdata & `CALOV_MAP_MASK) : map_q;
	assign fah_d = fah_wr ? reg_wdata : fah_q;
	assign fal_d = fal_wr ? reg_wdata : fal_q;
	assign fdh_d = fdh_wr ? reg_wdata : fdh_q;
	assign fdl_d = fdl_wr ? reg_wdata : fdl_q;

	// unused config bits read as zero
	assign cfg_val = {7'h00, su_mode_q} << `CALOV_SU_BIT;
	assign rd_mux = cfg_sel ? cfg_val :
		map_sel ? map_q :
		fah_sel ? fah_q :
		fal_sel ? fal_q :
		fdh_sel ? fdh_q :
		fdl_sel ? fdl_q :
		`CALOV_ZERO8;
	assign rdata_d = reg_rd ? rd_mux : `CALOV_ZERO8;

	// decode runs from the delayed map copy
	assign base_eff = map_eff_q[`CALOV_BASE_HI:`CALOV_BASE_LO];
	assign en_eff = map_eff_q[`CALOV_EN_BIT];
	assign hit_now = en_eff
		& (mem_addr[`CALOV_WIN_HI:`CALOV_WIN_LO] == base_eff);

	// a misaligned ram word is stretched to two cycles
	assign idle = state_q == calov_pkg::CALOV_IDLE;
	assign req = mem_rd | mem_wr;
	assign mis = mem_word & mem_addr[0];
	assign split = idle & req & mis & hit_now;
	assign mem_wait = split;

	always_comb begin
		case (state_q)
			calov_pkg::CALOV_IDLE: begin
				state_d = split ? calov_pkg::CALOV_SPLIT : calov_pkg::CALOV_IDLE;
			end
			calov_pkg::CALOV_SPLIT: begin
				state_d = calov_pkg::CALOV_IDLE;
			end
			default: begin
				state_d = calov_pkg::CALOV_IDLE;
			end
		endcase
	end

	assign acc_go = idle ? (req & ~split) : 1'b1;
	assign acc_hit = idle ? hit_now : 1'b1;
	assign acc_rd = idle ? mem_rd : h_rd_q;
	assign acc_wr = idle ? mem_wr : h_wr_q;
	assign acc_word = idle ? mem_word : 1'b1;
	assign acc_addr = idle ? mem_addr : h_addr_q;
	assign acc_wdata = idle ? mem_wdata : h_wdata_q;

	// big endian: the byte at the lower address is the high byte
	assign a_odd = acc_addr[0];
	assign idx = acc_addr[`CALOV_IDX_HI:`CALOV_IDX_LO];
	assign even_idx = idx + `CALOV_IDX_W'(acc_word & a_odd);
	assign ram_go = acc_go & acc_hit;
	assign even_we = ram_go & acc_wr & (acc_word | ~a_odd);
	assign odd_we = ram_go & acc_wr & (acc_word | a_odd);
	assign even_wd = (acc_word & ~a_odd) ? acc_wdata[15:8] : acc_wdata[7:0];
	assign odd_wd = (acc_word & a_odd) ? acc_wdata[15:8] : acc_wdata[7:0];

	calov_ram u_ram (
		.clk(clk),
		.ce(ce),
		.even_idx(even_idx),
		.even_we(even_we),
		.even_wdata(even_wd),
		.even_rdata(even_q),
		.odd_idx(idx),
		.odd_we(odd_we),
		.odd_wdata(odd_wd),
		.odd_rdata(odd_q)
	);

	// window misses go straight on to the flash
	assign flash_rd = idle & mem_rd & ~hit_now;
	assign flash_wr = idle & mem_wr & ~hit_now;
	assign flash_word = mem_word;
	assign flash_addr = mem_addr;
	assign flash_wdata = mem_wdata;

	// busy block is checked even under the overlay
	assign lock = chip_secured & special_single_chip;
	assign blk_busy = flash_busy[acc_addr[`CALOV_BLK_BIT]];
	assign rvalid_d = acc_go & acc_rd & ~blk_busy;
	assign src_d = ~(acc_go & acc_rd) ? calov_pkg::CALOV_SRC_NONE :
		~acc_hit ? calov_pkg::CALOV_SRC_FLASH :
		lock ? calov_pkg::CALOV_SRC_LOCK :
		calov_pkg::CALOV_SRC_RAM;

	assign ram_word = rd_odd_q ? {odd_q, even_q} : {even_q, odd_q};
	assign ram_byte = {`CALOV_ZERO8, rd_odd_q ? odd_q : even_q};
	assign lock_val = rd_word_q ? `CALOV_ONES16 : {`CALOV_ZERO8, `CALOV_ONES8};

	always_comb begin
		case (src_q)
			calov_pkg::CALOV_SRC_RAM: begin
				out_val = rd_word_q ? ram_word : ram_byte;
			end
			calov_pkg::CALOV_SRC_FLASH: begin
				out_val = flash_rdata;
			end
			calov_pkg::CALOV_SRC_LOCK: begin
				out_val = lock_val;
			end
			default: begin
				out_val = `CALOV_ZERO16;
			end
		endcase
	end

	// invalid reads show zero so stale data never leaks
	assign mem_rvalid = rvalid_q;
	assign mem_rdata = rvalid_q ? out_val : `CALOV_ZERO16;

	assign reg_rdata = rdata_q;
	assign flash_su_mode = su_mode_q;
	assign flash_address_staging = {fah_q, fal_q};
	assign flash_data_staging = {fdh_q, fdl_q};
	assign flash_stage_wr = stage_wr_q;

	// configuration and map registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			su_mode_q <= `CALOV_SU_RST;
			map_q <= `CALOV_MAP_RST;
			map_eff_q <= `CALOV_MAP_RST;
		end else if (ce) begin
			su_mode_q <= su_mode_d;
			map_q <= map_d;
			map_eff_q <= map_q;
		end
	end

	// staging registers, written only in super user mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fah_q <= `CALOV_ZERO8;
			fal_q <= `CALOV_ZERO8;
			fdh_q <= `CALOV_ZERO8;
			fdl_q <= `CALOV_ZERO8;
			stage_wr_q <= 1'b0;
		end else if (ce) begin
			fah_q <= fah_d;
			fal_q <= fal_d;
			fdh_q <= fdh_d;
			fdl_q <= fdl_d;
			stage_wr_q <= fdl_wr;
		end
	end

	// register read data, one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= `CALOV_ZERO8;
		end else if (ce) begin
			rdata_q <= rdata_d;
		end
	end

	// split access holding registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= calov_pkg::CALOV_IDLE;
			h_addr_q <= `CALOV_ZERO16;
			h_wdata_q <= `CALOV_ZERO16;
			h_rd_q <= 1'b0;
			h_wr_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			if (split) begin
				h_addr_q <= mem_addr;
				h_wdata_q <= mem_wdata;
				h_rd_q <= mem_rd;
				h_wr_q <= mem_wr;
			end
		end
	end

	// read return tracking
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			src_q <= calov_pkg::CALOV_SRC_NONE;
			rd_odd_q <= 1'b0;
			rd_word_q <= 1'b0;
		end else if (ce) begin
			rvalid_q <= rvalid_d;
			src_q <= src_d;
			rd_odd_q <= a_odd;
			rd_word_q <= acc_word;
		end
	end

endmodule : calov_top

// >>> calov_sva.sv
// Purpose: port checker for calov_top
// Assumes: ce held high
// Notes: helper regs track the map, lagging one cycle
`timescale 1ns/1ps
`include "calov_defs.svh"
module calov_sva (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// cpu port
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic mem_word,
	input wire logic mem_wait,
	input wire logic mem_rvalid,
	input wire logic [15:0] mem_rdata,
	// flash side
	input wire logic flash_rd,
	input wire logic flash_wr,
	input wire logic [1:0] flash_busy,
	input wire logic flash_su_mode,
	input wire logic chip_secured,
	input wire logic special_single_chip
);
	logic [7:0] map_q;
	logic [7:0] eff_q;
	logic win;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			map_q <= `CALOV_MAP_RST;
			eff_q <= `CALOV_MAP_RST;
		end else begin
			if (reg_wr && reg_addr == `CALOV_MAP_OFS)
				map_q <= reg_wdata & `CALOV_MAP_MASK;
			eff_q <= map_q;
		end
	end
	assign win = eff_q[0] && mem_addr[15:11] == eff_q[7:3];
	AST_SU_TAKE: assert property (reg_wr && reg_addr == `CALOV_CFG_OFS |=>
		flash_su_mode == $past(reg_wdata[7])) else $error("super user bit wrong");
	AST_CFG_READ: assert property (reg_rd && reg_addr == `CALOV_CFG_OFS |=>
		reg_rdata == {$past(flash_su_mode), 7'h00}) else $error("config read wrong");
	AST_RSV_ZERO: assert property (reg_rd && reg_addr > `CALOV_CFG_OFS |=>
		reg_rdata == 8'h00) else $error("reserved read not zero");
	AST_STAGE_HIDE: assert property (reg_rd && !flash_su_mode && reg_addr[7:2] == 6'h3c
		|=> reg_rdata == 8'h00) else $error("staging visible");
	AST_WIN_NO_FLASH: assert property ((mem_rd || mem_wr) && win |->
		!flash_rd && !flash_wr) else $error("window access reached flash");
	AST_OUT_FLASH: assert property (mem_rd && !win && !$past(mem_wait) |-> flash_rd)
		else $error("flash read missing");
	AST_MISAL: assert property (mem_rd && mem_word && mem_addr[0] && win && flash_busy == 2'h0
		|-> mem_wait ##1 !mem_rvalid ##1 mem_rvalid) else $error("split timing wrong");
	AST_BUSY: assert property (mem_rd && !mem_wait && flash_busy[mem_addr[15]] |=>
		!mem_rvalid && mem_rdata == 16'h0000) else $error("busy block gave data");
	AST_SECURE: assert property (mem_rd && !mem_wait && win && chip_secured
		&& special_single_chip && flash_busy == 2'h0 |=> mem_rvalid
		&& mem_rdata == ($past(mem_word) ? 16'hffff : 16'h00ff)) else $error("lock wrong");
	C_SPLIT: cover property (mem_wait ##2 mem_rvalid);
	C_WIN: cover property (mem_rd && win);
	C_SU: cover property (flash_su_mode && reg_rd);
endmodule : calov_sva
bind calov_top calov_sva u_sva (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_word, .mem_wait, .mem_rvalid,
	.mem_rdata, .flash_rd, .flash_wr, .flash_busy, .flash_su_mode, .chip_secured,
	.special_single_chip);

// >>> calov_flash_model.sv
// Purpose: flash array seen from the overlay
// Assumes: content is address xor key
// Notes: idle bus toggles so stale data never matches
`timescale 1ns/1ps
module calov_flash_model #(
	parameter logic [15:0] KEY = 16'h5a3c
) (
	// clock
	input wire logic clk,
	// flash port
	input wire logic flash_rd,
	input wire logic flash_wr,
	input wire logic [15:0] flash_addr,
	input wire logic [1:0] flash_busy,
	output logic [15:0] flash_rdata,
	// plain writes seen
	output int wr_cnt
);
	logic hit_q = 1'b0;
	logic [15:0] data_q = 16'h0000;
	logic [15:0] last_q = 16'h0000;
	initial wr_cnt = 0;
	always @(posedge clk) begin
		// busy block answers garbage
		hit_q <= flash_rd && !flash_busy[flash_addr[15]];
		data_q <= flash_addr ^ KEY;
		last_q <= flash_rdata;
		if (flash_wr) wr_cnt <= wr_cnt + 1;
	end
	assign flash_rdata = hit_q ? data_q : ~last_q;
endmodule : calov_flash_model

// >>> calov_top_bench.sv
// Purpose: self-checking bench for calov_top
// Assumes: ce held high, one clock
// Notes: flash content is address xor KEY
`timescale 1ns/1ps
module calov_top_bench;
	localparam logic [15:0] KEY = 16'h5a3c;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0, reg_rd = 1'b0, mem_rd = 1'b0, mem_wr = 1'b0, mem_word = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [15:0] mem_addr = 16'h0000, mem_wdata = 16'h0000, mem_rdata, flash_addr;
	logic [15:0] flash_rdata;
	logic [1:0] flash_busy = 2'h0;
	logic chip_secured = 1'b0, special_single_chip = 1'b0;
	logic mem_wait, mem_rvalid, flash_rd, flash_wr, flash_su_mode;
	logic flash_word, flash_stage_wr;
	logic [15:0] flash_wdata, flash_address_staging, flash_data_staging;
	int wr_cnt, miscompares = 0, samples_checked = 0, cycles = 0;
	calov_top u_dut (.clk, .rst, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_word, .mem_wdata, .mem_wait,
		.mem_rvalid, .mem_rdata, .flash_rd, .flash_wr, .flash_word, .flash_addr,
		.flash_wdata, .flash_rdata, .flash_busy, .flash_su_mode,
		.flash_address_staging, .flash_data_staging, .flash_stage_wr,
		.chip_secured, .special_single_chip);
	calov_flash_model #(.KEY(KEY)) u_flash (.clk, .flash_rd, .flash_wr, .flash_addr,
		.flash_busy, .flash_rdata, .wr_cnt);
	always #12.5 clk = ~clk;
	task automatic finish_test;
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, s);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
	endtask : rreg
	// one request; a split read waits its extra cycle
	task automatic cpu(input logic w, wd, input logic [15:0] a, d, output logic f, v,
		output logic [15:0] q);
		logic wt;
		@(posedge clk);
		mem_wr <= w;
		mem_rd <= !w;
		mem_word <= wd;
		mem_addr <= a;
		mem_wdata <= d;
		#1 f = flash_rd | flash_wr;
		wt = mem_wait;
		if (f) begin
			chk("flash_addr", a, flash_addr);
			chk("flash_wdata", d, flash_wdata);
			chk("flash_word", {15'h0, wd}, {15'h0, flash_word});
		end
		@(posedge clk);
		mem_wr <= 1'b0;
		mem_rd <= 1'b0;
		if (wt) @(posedge clk);
		#1 v = mem_rvalid;
		q = mem_rdata;
	endtask : cpu
	task automatic wr(input logic wd, input logic [15:0] a, d, input logic ef);
		logic f, v;
		logic [15:0] q;
		cpu(1'b1, wd, a, d, f, v, q);
		chk("flash write", {15'h0, ef}, {15'h0, f});
	endtask : wr
	task automatic rd(input logic wd, input logic [15:0] a, e, input logic ef, ev);
		logic f, v;
		logic [15:0] q;
		cpu(1'b0, wd, a, 16'h0000, f, v, q);
		chk("flash read", {15'h0, ef}, {15'h0, f});
		chk("mem_rvalid", {15'h0, ev}, {15'h0, v});
		chk("mem_rdata", e, q);
	endtask : rd
	task automatic t_cfg;
		rreg(8'hfc, 8'h00);
		rreg(8'hf8, 8'h10);
		rd(1'b1, 16'h1000, 16'h1000 ^ KEY, 1'b1, 1'b1);
		wreg(8'hfc, 8'hff);
		rreg(8'hfc, 8'h80);
		wreg(8'hf1, 8'ha5);
		rreg(8'hf1, 8'ha5);
		wreg(8'hf0, 8'h12);
		#1 chk("addr staging", 16'h12a5, flash_address_staging);
		wreg(8'hf2, 8'h9c);
		wreg(8'hf3, 8'h7e);
		#1 chk("stage_wr", 16'h0001, {15'h0, flash_stage_wr});
		chk("data staging", 16'h9c7e, flash_data_staging);
		@(posedge clk);
		#1 chk("stage_wr end", 16'h0000, {15'h0, flash_stage_wr});
		for (int a = 253; a < 256; a++) begin
			wreg(8'(a), 8'hff);
			rreg(8'(a), 8'h00);
		end
		wreg(8'hfc, 8'h00);
		wreg(8'hf1, 8'h33);
		#1 chk("hidden write", 16'h12a5, flash_address_staging);
		rreg(8'hf1, 8'h00);
	endtask : t_cfg
	task automatic t_map;
		logic [4:0] bs [4] = '{5'h00, 5'h01, 5'h1f, 5'h02};
		logic [15:0] a, d;
		foreach (bs[i]) begin
			a = {bs[i], 11'h000};
			d = {3'h0, bs[i], 8'h34};
			wreg(8'hf8, {bs[i], 3'h1});
			wr(1'b1, a, d, 1'b0);
			wr(1'b1, a ^ 16'h0800, d, 1'b1);
			rd(1'b1, a, d, 1'b0, 1'b1);
			rd(1'b1, a ^ 16'h0800, a ^ 16'h0800 ^ KEY, 1'b1, 1'b1);
		end
		chk("flash writes", 16'h0004, wr_cnt[15:0]);
		wr(1'b1, 16'h1002, 16'h5678, 1'b0);
		rd(1'b1, 16'h1001, 16'h3456, 1'b0, 1'b1);
		rd(1'b0, 16'h1001, 16'h0034, 1'b0, 1'b1);
	endtask : t_map
	task automatic t_lag;
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= 8'hf8;
		reg_wdata <= 8'h19;
		@(posedge clk);
		reg_wr <= 1'b0;
		mem_rd <= 1'b1;
		mem_addr <= 16'h1000;
		#1 chk("old map", 16'h0000, {15'h0, flash_rd});
		@(posedge clk);
		#1 chk("new map", 16'h0001, {15'h0, flash_rd});
		@(posedge clk);
		mem_rd <= 1'b0;
		wreg(8'hf8, 8'h11);
	endtask : t_lag
	task automatic t_lock;
		@(posedge clk);
		chip_secured <= 1'b1;
		special_single_chip <= 1'b1;
		rd(1'b1, 16'h1000, 16'hffff, 1'b0, 1'b1);
		rd(1'b0, 16'h1000, 16'h00ff, 1'b0, 1'b1);
		@(posedge clk);
		chip_secured <= 1'b0;
		flash_busy <= 2'h1;
		rd(1'b1, 16'h1000, 16'h0000, 1'b0, 1'b0);
		rd(1'b1, 16'h8000, 16'h8000 ^ KEY, 1'b1, 1'b1);
		@(posedge clk);
		flash_busy <= 2'h0;
	endtask : t_lock
	// sync reset would still show the bit 5 ns after the edge
	task automatic t_async;
		wreg(8'hfc, 8'h80);
		@(posedge clk);
		rst <= 1'b1;
		#5 chk("su after reset", 16'h0000, {15'h0, flash_su_mode});
		@(posedge clk);
		rst <= 1'b0;
		rreg(8'hf8, 8'h10);
	endtask : t_async
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_cfg();
		t_map();
		t_lag();
		t_lock();
		t_async();
		finish_test();
	end
endmodule : calov_top_bench
